// file: mpa_pkg.sv
// Purpose: constants and carriers for the nibble port, management port and address detect
// Assumes: system clock mclk at 100 MHz, link clocks from the transceiver
// Notes: no software registers; configuration arrives on plain inputs
// Operation
// [RQ1] transceiver supplies continuous nibble clocks, 2.5 MHz or 25 MHz
// [RQ2] transceiver keeps both nibble clocks glitch free when switching
// [RQ3] new transmit nibble each tx edge while enabled, zeros otherwise
// [RQ4] transmit enable rises with first preamble nibble, drops after last nibble
// [RQ5] receive nibble captured each rx edge while valid, ignored otherwise
// [RQ6] transceiver frames valid from first delimiter nibble through last crc nibble
// [RQ7] error seen while valid marks the frame with a crc error
// [RQ8] error and code groups ignored while valid is low
// [RQ9] transceiver raises collision on medium collision
// [RQ10] transceiver raises carrier whenever medium is not idle
// [RQ11] management clock toggles near 2.5 MHz only during an operation, else low
// [RQ12] data pin driven in header and write data, released for read, idle undriven
// [RQ13] driven management data changes only on management clock falling edges
// [RQ14] external accept ORed with internal match decides frame acceptance
// [RQ15] byte strobe rises one rx period after delimiter, for one nibble time
// [RQ16] byte strobe then toggles every nibble, rising on each byte's first nibble
// [RQ17] byte strobe inactive except during frame reception
// [RQ18] byte strobe routable to any led output
// [RQ19] with interface select and tagging enabled, tag pin becomes serial tag input
// [RQ20] under same enables, second tag pin qualifies the tag data
// [RQ21] transmit and receive logic on phy clocks, crossings into system domain
package mpa_pkg;
  localparam int MPA_CLK_MHZ = 100;
  localparam int MPA_MDC_KHZ = 2500;
  // half period of the management clock in system cycles
  localparam int MPA_MDC_HALF = (MPA_CLK_MHZ * 1000) / (2 * MPA_MDC_KHZ);
  localparam int MPA_MGMT_BITS = 64;
  localparam int MPA_HDR_BITS = 46;
  localparam int MPA_TA_BIT = 46;
  localparam logic [3:0] MPA_SFD_NIB = 4'hD;
  localparam logic [3:0] MPA_NIB_ZERO = 4'h0;
  localparam logic [1:0] MPA_OP_WRITE = 2'h1;
  localparam logic [1:0] MPA_OP_READ = 2'h2;
  localparam int MPA_LEDS = 4;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] reg_a;
    logic [15:0] wdata;
  } mpa_mgmt_req_t;

  typedef struct packed {
    logic crc_err;
    logic accepted;
    logic [15:0] nibbles;
  } mpa_rx_stat_t;

  typedef enum logic [1:0] {
    MPA_RX_IDLE = 2'b00,
    MPA_RX_PRE = 2'b01,
    MPA_RX_DATA = 2'b11
  } mpa_rx_st_t;
endpackage : mpa_pkg

// file: mpa_mii_port.sv
// Purpose: nibble transmit/receive, management port and address detect strobe
// Assumes: tx_clk and rx_clk come from the transceiver; mclk is the system clock
// Notes: frame data enters as a nibble stream; status crosses by toggle handshake
`timescale 1ns/10ps
module mpa_mii_port import mpa_pkg::*; #(
  parameter int LEDS = MPA_LEDS
) (
  // system
  input wire logic mclk,
  input wire logic rstn,
  // transmit stream (mclk)
  input wire logic tx_valid,
  input wire logic [3:0] tx_nib,
  input wire logic tx_last,
  output logic tx_ready,
  // transmit pins (tx_clk)
  input wire logic tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  // receive pins (rx_clk; col and crs are synchronised into mclk)
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic col,
  input wire logic crs,
  // receive status (mclk); internal_match is sampled on rx_clk
  input wire logic internal_match,
  output mpa_rx_stat_t rx_stat,
  output logic rx_stat_pulse,
  output logic col_sync,
  output logic crs_sync,
  // address detect
  input wire logic external_address_accept,
  input wire logic addr_detect_if_select,
  input wire logic rx_frame_tagging_enable,
  input wire logic rx_tag_serial_in,
  input wire logic rx_tag_valid_in,
  output logic [15:0] rx_tag,
  output logic [LEDS-1:0] led_byte_strobe,
  input wire logic [1:0] strobe_led_sel,
  output logic byte_boundary_strobe,
  // management
  input wire logic mgmt_start,
  input wire mpa_mgmt_req_t mgmt_req,
  output logic mgmt_busy,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_done,
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic mdio_i
);
  initial begin
    if (LEDS < 1 || LEDS > 4) $error("LEDS must be 1..4");
  end

  // ---------------- transmit (tx_clk) ----------------
  // eight-entry gray-pointer fifo: a per-nibble handshake cannot keep tx_en unbroken
  // across the crossing, so the source fills ahead and the tx side drains one per edge
  logic [4:0] txf_mem_r [8];
  logic [3:0] twb_r, twb_nxt, twg_r, trb_r, trb_nxt, trg_r;
  logic [3:0] rg_seen_r, rg_seen_nxt, wg_seen_r, wg_seen_nxt;
  logic [11:0] rgs_r, wgs_r;
  logic txf_we, tx_gap_r, tx_gap_nxt;
  logic [3:0] txd_nxt;
  logic tx_en_nxt;
  logic [2:0] trst_r, rrst_r;
  wire tx_rst = ~trst_r[2];
  wire rx_rst = ~rrst_r[2];

  function automatic logic [3:0] to_gray(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction : to_gray

  // a pointer counts once its second and third stages agree  RQ21
  always_comb begin
    rg_seen_nxt = (rgs_r[11:8] == rgs_r[7:4]) ? rgs_r[7:4] : rg_seen_r;
    txf_we = tx_valid & tx_ready;
    twb_nxt = txf_we ? twb_r + 4'h1 : twb_r;
    wg_seen_nxt = (wgs_r[11:8] == wgs_r[7:4]) ? wgs_r[7:4] : wg_seen_r;
    trb_nxt = trb_r;
    tx_gap_nxt = 1'b0;
    txd_nxt = MPA_NIB_ZERO; // RQ3
    tx_en_nxt = 1'b0;
    // one idle edge after a last nibble keeps frames apart
    if (!tx_gap_r && (to_gray(trb_r) != wg_seen_r)) begin
      trb_nxt = trb_r + 4'h1;
      {tx_gap_nxt, txd_nxt} = txf_mem_r[trb_r[2:0]]; // RQ3
      tx_en_nxt = 1'b1; // RQ4
    end
  end

  // full once the write pointer is a whole lap ahead of the read pointer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      {twb_r, twg_r, rg_seen_r, rgs_r} <= '0;
      tx_ready <= 1'b0;
    end else begin
      twb_r <= twb_nxt;
      twg_r <= to_gray(twb_nxt);
      rgs_r <= {rgs_r[7:0], trg_r};
      rg_seen_r <= rg_seen_nxt;
      tx_ready <= to_gray(twb_nxt) != {~rg_seen_nxt[3:2], rg_seen_nxt[1:0]};
    end
    if (txf_we) txf_mem_r[twb_r[2:0]] <= {tx_last, tx_nib};
  end

  // the source must keep the fifo fed; running dry ends tx_en  RQ4
  always_ff @(posedge tx_clk) begin
    trst_r <= {trst_r[1:0], rstn};
    if (tx_rst) begin
      {wgs_r, wg_seen_r, trb_r, trg_r, tx_gap_r, tx_en} <= '0;
      txd <= MPA_NIB_ZERO;
    end else begin
      wgs_r <= {wgs_r[7:0], twg_r};
      wg_seen_r <= wg_seen_nxt;
      trb_r <= trb_nxt;
      trg_r <= to_gray(trb_nxt);
      tx_gap_r <= tx_gap_nxt;
      txd <= txd_nxt; // RQ3
      tx_en <= tx_en_nxt; // RQ4
    end
  end

  // ---------------- receive (rx_clk) ----------------
  mpa_rx_st_t rx_st_r, rx_st_nxt;
  logic crc_err_r, crc_err_nxt, ear_ok_r, ear_ok_nxt, bbs_r, bbs_nxt;
  logic [15:0] cnt_r, cnt_nxt, tag_r, tag_nxt;
  logic done_tg_r, done_tg_nxt;
  mpa_rx_stat_t hold_r, hold_nxt;
  logic tag_on;

  // tag pins only meaningful with both enables  RQ19 RQ20
  assign tag_on = addr_detect_if_select & rx_frame_tagging_enable;

  always_comb begin
    rx_st_nxt = rx_st_r;
    crc_err_nxt = crc_err_r;
    ear_ok_nxt = ear_ok_r;
    bbs_nxt = 1'b0; // RQ17
    cnt_nxt = cnt_r;
    tag_nxt = tag_r;
    done_tg_nxt = done_tg_r;
    hold_nxt = hold_r;
    if (tag_on && rx_tag_valid_in) begin
      tag_nxt = {tag_r[14:0], rx_tag_serial_in}; // RQ19 RQ20
    end
    unique case (rx_st_r)
      MPA_RX_IDLE: begin
        // rx_er and code groups ignored without rx_dv  RQ8
        if (rx_dv) begin
          rx_st_nxt = MPA_RX_PRE;
          crc_err_nxt = rx_er; // RQ7
          ear_ok_nxt = external_address_accept;
          cnt_nxt = 16'h0000;
        end
      end
      MPA_RX_PRE: begin
        if (!rx_dv) begin
          rx_st_nxt = MPA_RX_IDLE;
        end else begin
          crc_err_nxt = crc_err_r | rx_er; // RQ7
          ear_ok_nxt = ear_ok_r & external_address_accept;
          if (rxd == MPA_SFD_NIB && !rx_er) begin
            rx_st_nxt = MPA_RX_DATA;
            bbs_nxt = 1'b1; // RQ15
          end
        end
      end
      MPA_RX_DATA: begin
        if (rx_dv) begin
          cnt_nxt = cnt_r + 16'h0001; // RQ5
          crc_err_nxt = crc_err_r | rx_er; // RQ7
          ear_ok_nxt = ear_ok_r & external_address_accept;
          bbs_nxt = ~bbs_r; // RQ16
        end else begin
          rx_st_nxt = MPA_RX_IDLE;
          hold_nxt.crc_err = crc_err_r;
          hold_nxt.accepted = ear_ok_r | internal_match; // RQ14
          hold_nxt.nibbles = cnt_r;
          done_tg_nxt = ~done_tg_r;
        end
      end
      default: rx_st_nxt = MPA_RX_IDLE;
    endcase
  end

  always_ff @(posedge rx_clk) begin
    rrst_r <= {rrst_r[1:0], rstn};
    if (rx_rst) begin
      rx_st_r <= MPA_RX_IDLE;
      crc_err_r <= 1'b0;
      ear_ok_r <= 1'b0;
      bbs_r <= 1'b0;
      cnt_r <= 16'h0000;
      tag_r <= 16'h0000;
      done_tg_r <= 1'b0;
      hold_r <= '0;
    end else begin
      rx_st_r <= rx_st_nxt;
      crc_err_r <= crc_err_nxt;
      ear_ok_r <= ear_ok_nxt;
      bbs_r <= bbs_nxt; // RQ15 RQ16
      cnt_r <= cnt_nxt;
      tag_r <= tag_nxt;
      done_tg_r <= done_tg_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign byte_boundary_strobe = bbs_r;
  generate
    for (genvar i = 0; i < LEDS; i++) begin : g_led
      assign led_byte_strobe[i] = bbs_r & (strobe_led_sel == 2'(i)); // RQ18
    end
  endgenerate

  // ---------------- crossings into mclk ----------------  RQ21
  logic [2:0] dtg_r, col_r, crs_r;
  logic dtg_seen_r;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dtg_r <= 3'h0;
      col_r <= 3'h0;
      crs_r <= 3'h0;
      dtg_seen_r <= 1'b0;
      rx_stat <= '0;
      rx_stat_pulse <= 1'b0;
      rx_tag <= 16'h0000;
      col_sync <= 1'b0;
      crs_sync <= 1'b0;
    end else begin
      dtg_r <= {dtg_r[1:0], done_tg_r};
      col_r <= {col_r[1:0], col};
      crs_r <= {crs_r[1:0], crs};
      rx_stat_pulse <= 1'b0;
      if (col_r[2] == col_r[1]) col_sync <= col_r[1];
      if (crs_r[2] == crs_r[1]) crs_sync <= crs_r[1];
      // hold_r is stable long before the toggle settles
      if ((dtg_r[2] == dtg_r[1]) && (dtg_r[1] != dtg_seen_r)) begin
        dtg_seen_r <= dtg_r[1];
        rx_stat <= hold_r;
        rx_tag <= tag_r;
        rx_stat_pulse <= 1'b1;
      end
    end
  end

  // ---------------- management port (mclk) ----------------
  logic [6:0] div_r, div_nxt;
  logic [6:0] bit_r, bit_nxt;
  logic [63:0] sh_r, sh_nxt;
  logic [15:0] rd_r, rd_nxt;
  logic busy_r, busy_nxt, mdc_nxt, oe_nxt, o_nxt, done_nxt, rd_op_r, rd_op_nxt;
  logic [2:0] mdi_r;

  always_comb begin
    div_nxt = div_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    busy_nxt = busy_r;
    rd_op_nxt = rd_op_r;
    mdc_nxt = 1'b0; // RQ11
    oe_nxt = 1'b0; // RQ12
    o_nxt = mdio_o;
    done_nxt = 1'b0;
    if (!busy_r) begin
      if (mgmt_start) begin
        busy_nxt = 1'b1;
        rd_op_nxt = (mgmt_req.op == MPA_OP_READ);
        // 32 preamble ones, start 01, op, phy, reg, turnaround, data
        sh_nxt = {32'hFFFFFFFF, 2'b01, mgmt_req.op, mgmt_req.phy, mgmt_req.reg_a,
                  2'b10, mgmt_req.wdata};
        div_nxt = 7'd0;
        bit_nxt = 7'd0;
        o_nxt = 1'b1;
        oe_nxt = 1'b1;
      end
    end else begin
      mdc_nxt = mdc;
      oe_nxt = mdio_oe;
      div_nxt = div_r + 7'd1;
      if (div_r == 7'(MPA_MDC_HALF - 1)) begin
        div_nxt = 7'd0;
        mdc_nxt = ~mdc; // RQ11
        if (mdc) begin
          // falling edge: advance drive  RQ13
          sh_nxt = {sh_r[62:0], 1'b0};
          bit_nxt = bit_r + 7'd1;
          o_nxt = sh_r[62];
          oe_nxt = !(rd_op_r && (bit_r + 7'd1) >= 7'(MPA_HDR_BITS)); // RQ12
          if (bit_r == 7'(MPA_MGMT_BITS - 1)) begin
            busy_nxt = 1'b0;
            mdc_nxt = 1'b0;
            oe_nxt = 1'b0; // RQ12
            done_nxt = 1'b1;
          end
        end else if (rd_op_r && bit_r > 7'(MPA_TA_BIT)) begin
          rd_nxt = {rd_r[14:0], mdi_r[2]};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      div_r <= 7'd0;
      bit_r <= 7'd0;
      sh_r <= 64'h0;
      rd_r <= 16'h0000;
      busy_r <= 1'b0;
      rd_op_r <= 1'b0;
      mdi_r <= 3'h0;
      mdc <= 1'b0;
      mdio_oe <= 1'b0;
      mdio_o <= 1'b0;
      mgmt_done <= 1'b0;
      mgmt_busy <= 1'b0;
      mgmt_rdata <= 16'h0000;
    end else begin
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      busy_r <= busy_nxt;
      rd_op_r <= rd_op_nxt;
      mdi_r <= {mdi_r[1:0], mdio_i};
      mdc <= mdc_nxt; // RQ11
      mdio_oe <= oe_nxt; // RQ12
      mdio_o <= o_nxt; // RQ13
      mgmt_done <= done_nxt;
      mgmt_busy <= busy_nxt;
      if (done_nxt) mgmt_rdata <= rd_r;
    end
  end
endmodule : mpa_mii_port

// file: mpa_mii_port_properties.sv
// Purpose: port checks for the nibble port, management port and byte strobe
// Assumes: sees only the top ports; tx_clk and rx_clk come from the transceiver
// Notes: bound to every mpa_mii_port below the module
`timescale 1ns/10ps
module mpa_chk import mpa_pkg::*; #(
  parameter int LEDS = MPA_LEDS
) (
  // clocks and reset
  input wire logic mclk,
  input wire logic rstn,
  input wire logic tx_clk,
  input wire logic rx_clk,
  // watched pins
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic rx_dv,
  input wire logic byte_boundary_strobe,
  input wire logic [LEDS-1:0] led_byte_strobe,
  input wire logic [1:0] strobe_led_sel,
  input wire logic mgmt_busy,
  input wire logic mgmt_done,
  input wire logic rx_stat_pulse,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  AST_TXD_ZERO: assert property (@(posedge tx_clk) disable iff (!rstn) !tx_en |-> txd == 4'h0)
    else $error("txd not zero while idle");
  AST_MDC_IDLE: assert property (@(posedge mclk) disable iff (!rstn) !mgmt_busy |=> !mdc)
    else $error("mdc moved while idle");
  AST_MDC_HALF: assert property (@(posedge mclk) disable iff (!rstn) $rose(mdc) |-> mdc[*8] ##13 $fell(mdc))
    else $error("mdc high phase wrong");
  AST_MDIO_REL: assert property (@(posedge mclk) disable iff (!rstn) !mgmt_busy |-> !mdio_oe)
    else $error("mdio driven while idle");
  AST_MDIO_EDGE: assert property (@(posedge mclk) disable iff (!rstn)
    mdio_oe && $past(mdio_oe) && $changed(mdio_o) |-> $fell(mdc))
    else $error("mdio changed off falling mdc");
  AST_STB_IDLE: assert property (@(posedge rx_clk) disable iff (!rstn)
    !rx_dv && !$past(rx_dv) |-> !byte_boundary_strobe)
    else $error("strobe outside frame");
  AST_STB_TOGGLE: assert property (@(posedge rx_clk) disable iff (!rstn)
    byte_boundary_strobe |=> !byte_boundary_strobe)
    else $error("strobe high two nibbles");
  AST_STB_LED: assert property (@(posedge rx_clk) disable iff (!rstn)
    led_byte_strobe == (LEDS'(byte_boundary_strobe) << strobe_led_sel))
    else $error("led routing wrong");
  COV_MGMT: cover property (@(posedge mclk) mgmt_done);
  COV_RX: cover property (@(posedge mclk) rx_stat_pulse);
  COV_STB: cover property (@(posedge rx_clk) $rose(byte_boundary_strobe));
endmodule : mpa_chk

bind mpa_mii_port mpa_chk #(.LEDS(LEDS)) u_chk (.mclk, .rstn, .tx_clk, .rx_clk, .txd, .tx_en,
  .rx_dv, .byte_boundary_strobe, .led_byte_strobe, .strobe_led_sel, .mgmt_busy, .mgmt_done,
  .rx_stat_pulse, .mdc, .mdio_o, .mdio_oe);

// file: mpa_phy_model.sv
// Purpose: transceiver and address matcher model facing the nibble port
// Assumes: 10 Mbps transmit clock, fast free running receive clock
// Notes: management data is pulled up when nobody drives it
`timescale 1ns/10ps
module mpa_phy_model import mpa_pkg::*; (
  // link clocks
  output logic tx_clk,
  output logic rx_clk,
  // nibble pins
  input wire logic [3:0] txd,
  input wire logic tx_en,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic col,
  output logic crs,
  // address detect
  output logic external_address_accept,
  output logic rx_tag_serial_in,
  output logic rx_tag_valid_in,
  input wire logic byte_boundary_strobe,
  // management
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mgmt_start,
  input wire logic [15:0] rd_val,
  output logic phy_oe,
  output logic phy_d
);
  logic [3:0] txq[$];
  logic [63:0] mframe;
  logic [1:0] op;
  logic ten_q = 1'b0;
  logic stb_q = 1'b0;
  int mcnt, stb_rises, tx_bursts;
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    {rxd, rx_dv, rx_er, col, crs, phy_oe, phy_d} = '0;
    {external_address_accept, rx_tag_serial_in, rx_tag_valid_in} = '0;
  end
  always #200 tx_clk = ~tx_clk;
  initial #3 forever #6 rx_clk = ~rx_clk;
  always @(posedge tx_clk) begin
    if (tx_en) txq.push_back(txd);
    if (tx_en && !ten_q) tx_bursts++;
    ten_q = tx_en;
  end
  always @(posedge rx_clk) begin
    // a rise seen after rx_dv drops marks no byte and is not counted
    if (byte_boundary_strobe && !stb_q && rx_dv) stb_rises++;
    stb_q = byte_boundary_strobe;
  end
  always @(posedge mgmt_start) mcnt = 0;
  always @(posedge mdc) begin
    mframe = {mframe[62:0], mdio_o};
    mcnt++;
    if (mcnt == 36) op = mframe[1:0];
  end
  // answer after the falling edge so the sampling edge sees settled data
  always @(negedge mdc) begin
    phy_oe = op == MPA_OP_READ && mcnt >= 47 && mcnt <= 63;
    phy_d = mcnt == 47 ? 1'b0 : rd_val[63-mcnt];
  end
  task automatic send(input int n, input int er_at, input logic ext, input logic [15:0] tag);
    logic [3:0] nib;
    @(posedge rx_clk);
    rx_er <= 1'b1;
    rxd <= MPA_SFD_NIB;
    @(posedge rx_clk);
    crs <= 1'b1;
    external_address_accept <= ext;
    for (int i = 0; i < n + 8; i++) begin
      nib = i < 7 ? 4'h5 : (i == 7 ? MPA_SFD_NIB : 4'($urandom));
      rx_dv <= 1'b1;
      rxd <= nib;
      rx_er <= i == er_at;
      rx_tag_valid_in <= i < 16;
      rx_tag_serial_in <= tag[15-(i%16)];
      @(posedge rx_clk);
    end
    {rx_dv, rx_er, crs, external_address_accept, rx_tag_valid_in} <= '0;
    rxd <= ~nib;
  endtask : send
endmodule : mpa_phy_model

// file: testbench.sv
// Purpose: self checking bench for the nibble port
// Assumes: reset held until every link domain has seen it
// Notes: expectations come from a small behavioural model in the main sequence
`timescale 1ns/10ps
module testbench import mpa_pkg::*;;
  logic mclk = 0, rstn = 0, tx_valid = 0, tx_last = 0, internal_match = 0, mgmt_start = 0;
  logic addr_detect_if_select = 1, rx_frame_tagging_enable = 1;
  logic [3:0] tx_nib = 4'h0;
  logic [1:0] strobe_led_sel = 2'h0;
  logic [15:0] rd_val = 16'h0;
  mpa_mgmt_req_t mgmt_req = '0;
  logic tx_ready, tx_clk, tx_en, rx_clk, rx_dv, rx_er, col, crs, rx_stat_pulse, col_sync;
  logic crs_sync, external_address_accept, rx_tag_serial_in, rx_tag_valid_in, phy_oe, phy_d;
  logic byte_boundary_strobe, mgmt_busy, mgmt_done, mdc, mdio_o, mdio_oe;
  logic [3:0] txd, rxd, led_byte_strobe;
  logic [15:0] rx_tag, mgmt_rdata, tag;
  mpa_rx_stat_t rx_stat;
  wire logic mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_d : 1'b1);
  logic [3:0] exp[$];
  int miscompares, n_checks, cyc, rises, w;
  mpa_mii_port u_dut (.mclk, .rstn, .tx_valid, .tx_nib, .tx_last, .tx_ready, .tx_clk, .txd, .tx_en,
    .rx_clk, .rxd, .rx_dv, .rx_er, .col, .crs, .internal_match, .rx_stat, .rx_stat_pulse, .col_sync,
    .crs_sync, .external_address_accept, .addr_detect_if_select, .rx_frame_tagging_enable,
    .rx_tag_serial_in, .rx_tag_valid_in, .rx_tag, .led_byte_strobe, .strobe_led_sel,
    .byte_boundary_strobe, .mgmt_start, .mgmt_req, .mgmt_busy, .mgmt_rdata, .mgmt_done, .mdc,
    .mdio_o, .mdio_oe, .mdio_i);
  mpa_phy_model u_phy (.tx_clk, .rx_clk, .txd, .tx_en, .rxd, .rx_dv, .rx_er, .col, .crs,
    .external_address_accept, .rx_tag_serial_in, .rx_tag_valid_in, .byte_boundary_strobe, .mdc,
    .mdio_o, .mgmt_start, .rd_val, .phy_oe, .phy_d);
  always #5 mclk = ~mclk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  always @(posedge mclk) if (++cyc == 20000) begin
    miscompares++;
    end_sim();
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic await(ref logic s);
    do @(negedge mclk); while (s !== 1'b1);
  endtask : await
  initial begin
    void'($urandom(30));
    // long reset so the slow transmit domain sees it
    repeat (170) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) exp.push_back(4'($urandom));
    foreach (exp[i]) begin
      tx_valid <= 1'b1;
      tx_nib <= exp[i];
      tx_last <= i == 7;
      await(tx_ready);
      @(posedge mclk);
    end
    tx_valid <= 1'b0;
    w = 0;
    while (u_phy.txq.size() < 8 && w++ < 3000) @(posedge mclk);
    foreach (exp[i]) chk("txd", exp[i], u_phy.txq[i]);
    chk("tx bursts", 1, u_phy.tx_bursts);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      mgmt_req <= '{k ? MPA_OP_READ : MPA_OP_WRITE, 5'($urandom), 5'($urandom), 16'($urandom)};
      rd_val <= 16'($urandom);
      mgmt_start <= 1'b1;
      @(posedge mclk);
      mgmt_start <= 1'b0;
      await(mgmt_done);
      if (k) chk("mgmt_rdata", rd_val, mgmt_rdata);
      else chk("mdio frame", {32'hFFFFFFFF, 2'b01, mgmt_req.op, mgmt_req.phy, mgmt_req.reg_a,
        2'b10, mgmt_req.wdata}, u_phy.mframe);
    end
    for (int k = 0; k < 4; k++) begin
      strobe_led_sel <= 2'(k);
      internal_match <= k[0];
      tag = 16'($urandom);
      rises = u_phy.stb_rises;
      u_phy.send(8, k >= 2 ? 8 + k : -1, k[1], tag);
      await(rx_stat_pulse);
      chk("crc_err", k >= 2, rx_stat.crc_err);
      chk("accepted", k[0] | k[1], rx_stat.accepted);
      chk("nibbles", 8, rx_stat.nibbles);
      chk("rx_tag", tag, rx_tag);
      chk("strobe rises", 4, u_phy.stb_rises - rises);
    end
    for (int v = 1; v >= 0; v--) begin
      @(posedge mclk);
      u_phy.col <= v[0];
      u_phy.crs <= v[0];
      repeat (5) @(posedge mclk);
      chk("col_sync", v, col_sync);
      chk("crs_sync", v, crs_sync);
    end
    end_sim();
  end
endmodule : testbench
